// ===== af_defines.svh
// Constants for the auxiliary channel filter and calibration block.
// Assumes a 125 MHz pclk; included by the design file by its bare name.
`ifndef AF_DEFINES_SVH
`define AF_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets and result register indices on the APB side
// ----------------------------------------------------------------
`define AF_CTRL_OFS 8'h00
`define AF_OFFSET_OFS 8'h04
`define AF_GAIN_OFS 8'h08
`define AF_STATUS_OFS 8'h0c
`define AF_RESULT_FIRST_IDX 8'h10
`define AF_RESULT_LAST_IDX 8'h1f

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define AF_CTRL_OSR_LSB 0
`define AF_STATUS_BUSY_BIT 0
`define AF_STATUS_STEP_LSB 4
`define AF_OSR_RESET 2'h0
`define AF_OFFSET_RESET 16'h0000
`define AF_GAIN_RESET 16'h0000

// ----------------------------------------------------------------
// Timing: conversion lengths in pclk cycles per oversampling select
// ----------------------------------------------------------------
`define AF_MOD_DIV 2
`define AF_SINC3_DEC 7'h40
`define AF_SINC3_SETTLE 4'h2
`define AF_CONV_OSR64 11'h180
`define AF_CONV_OSR128 11'h200
`define AF_CONV_OSR256 11'h300
`define AF_CONV_OSR512 11'h500

// ----------------------------------------------------------------
// Code limits and calibration scaling
// ----------------------------------------------------------------
`define AF_POS_FS16 38'sh0000007fff
`define AF_NEG_FS16 38'sh3fffff8000
`define AF_POS_FS24 32'sh007fffff
`define AF_NEG_FS24 32'shff800000
`define AF_GAIN_UNITY 18'h10000
`define AF_ROUND_HALF 38'sh0000008000
`define AF_GAIN_FRAC 16
`define AF_SHIFT_BASE 3'h3

`endif

// ===== af_pkg.sv
// Types for the auxiliary channel filter and calibration block.
// Assumes the constants of af_defines.svh are visible to its users.
package af_pkg;

    // Conversion sequencing
    typedef enum logic [0:0] {
        AF_IDLE,
        AF_CONVERT
    } af_state_type;

    // Positive selector choices
    typedef enum logic [3:0] {
        AF_POS_IN0, AF_POS_IN1, AF_POS_IN2, AF_POS_IN3,
        AF_POS_IN4, AF_POS_IN5, AF_POS_IN6, AF_POS_IN7,
        AF_POS_TEMP, AF_POS_SHORT, AF_POS_TEST_DAC, AF_POS_SUP_APWR,
        AF_POS_SUP_DPWR, AF_POS_SUP_AVDD, AF_POS_SUP_IOVDD, AF_POS_SUP_DVDD
    } af_pos_type;

    // Amplifier gain codes
    typedef enum logic [1:0] {
        AF_GAIN_X1,
        AF_GAIN_X2,
        AF_GAIN_X4,
        AF_GAIN_X4_ALT
    } af_gain_type;

    // Whole state of the block
    typedef struct packed {
        af_state_type state;
        logic [10:0] cnt;
        logic [3:0] dec;
        logic [1:0] osr;
        logic [15:0] offset;
        logic [15:0] gain;
        logic [3:0] step;
        logic [3:0] last_step;
        af_pos_type pos_sel;
        logic neg_sel;
        af_gain_type gsel;
        logic [20:0] i1;
        logic [20:0] i2;
        logic [20:0] i3;
        logic [20:0] d1;
        logic [20:0] d2;
        logic [20:0] d3;
        logic [23:0] acc;
        logic [15:0][15:0] result;
        logic [31:0] prdata;
        logic done;
        logic [23:0] cur_code;
    } af_reg_type;

endpackage

// ===== af_filter_cal.sv
// Auxiliary converter back end: input selection, single-shot sinc3/sinc1
// decimation, offset and gain correction, result registers on APB, and the
// 24-bit current-channel code clipper.
// Assumes an external sequencer pulses step_start once per step and waits
// for step_done; the modulator bit is valid on cycles flagged mod_clk_en.
// Register accesses never stall: pready is tied high.
// Changing the oversampling select mid-conversion changes its length.
//
// Function
// - Current result is 24-bit two's complement, clipped at 7FFFFFh and 800000h.
// - Amplifier inputs follow the positive and negative selects of the active step.
// - Positive choices: eight inputs, temp sensor, ground short, test DAC, supplies.
// - Non-pin positive choice disconnects inputs and forces negative to ground.
// - Two-bit gain select per step gives gain 1, 2 or 4.
// - Unipolar single-ended results use only codes 0000h to 7FFFh.
// - Modulator runs at half the main clock; timing derives from it.
// - Single-shot conversions from the sequencer; filter cleared at each start.
// - Only fully settled results are delivered; earlier outputs are dropped.
// - OSR 64 is pure sinc3; 128/256/512 add sinc1 over 2, 4, 8 outputs.
// - Conversion lasts 384, 512, 768, 1280 main clocks for OSR 64 to 512.
// - One offset and gain for all steps, bypassed for temperature sensor steps.
// - Subtract signed 16-bit offset first, then multiply by gain factor.
// - Round the scaled value to 16 bits and clip at full scale.
// - Offset is two's complement and subtracted from the result.
// - Offset count weighs twice as much at gain 4 as at gain 1 or 2.
// - Gain factor is one plus the signed value over 65536.
// - Step results sit at register indices 10h to 1Fh for host reads.
// - 16-bit result is two's complement, clipped at 7FFFh and 8000h.
`timescale 1ns/1ps
`include "af_defines.svh"

module af_filter_cal (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic step_start,
    input wire logic [3:0] step_index,
    input wire logic [3:0] step_positive_select,
    input wire logic step_negative_select,
    input wire logic [1:0] step_gain_select,
    input wire logic mod_bit,
    output logic [3:0] aux_input_selector_pos,
    output logic aux_input_selector_neg,
    output logic analog_inputs_connected,
    output logic [1:0] pga_gain,
    output logic mod_clk_en,
    output logic step_done,
    output logic aux_busy,
    input wire logic cur_valid,
    input wire logic [31:0] cur_value,
    output logic [23:0] cur_code
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // Clip a wide signed value to the 16-bit code range
    function automatic logic [15:0] sat16(input logic signed [37:0] v);
        logic [15:0] res;
        // In-range values keep their low 16 bits
        res = v[15:0];
        if (v > `AF_POS_FS16) begin
            res = 16'h7fff;
        end else if (v < `AF_NEG_FS16) begin
            res = 16'h8000;
        end
        return res;
    endfunction

    // Conversion length in pclk cycles for an oversampling select
    function automatic logic [10:0] conv_len(input logic [1:0] osr);
        logic [10:0] res;
        // Two settling sinc3 periods plus the sinc1 average
        res = `AF_CONV_OSR64;
        unique case (osr)
            2'h0: res = `AF_CONV_OSR64;
            2'h1: res = `AF_CONV_OSR128;
            2'h2: res = `AF_CONV_OSR256;
            2'h3: res = `AF_CONV_OSR512;
        endcase
        return res;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------

    af_pkg::af_reg_type r;
    af_pkg::af_reg_type n;

    // Sinc3 and sinc1 datapath
    logic [20:0] x;
    logic [20:0] i1_n;
    logic [20:0] i2_n;
    logic [20:0] i3_n;
    logic [20:0] c1;
    logic [20:0] c2;
    logic [20:0] c3;
    logic [23:0] acc_n;
    logic dec_tick;
    logic last;
    logic [2:0] shamt;
    logic signed [37:0] raw_wide;
    logic [15:0] raw16;

    // Offset and gain correction
    logic [17:0] off_eff;
    logic [18:0] diff;
    logic [17:0] factor;
    logic signed [36:0] prod;
    logic signed [37:0] rounded;
    logic [15:0] corrected;
    logic is_temp;

    // Register bus decode
    logic setup;
    logic access;
    logic mapped;
    logic [7:0] idx;
    logic is_result;
    logic [31:0] rdata;

    // Current channel
    logic signed [31:0] cur_s;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------

    // Result registers sit at byte address four times their index
    assign idx = {2'h0, paddr[7:2]};
    assign is_result = (paddr[1:0] == 2'h0) && (idx >= `AF_RESULT_FIRST_IDX)
        && (idx <= `AF_RESULT_LAST_IDX);
    // Every decoded register answers without error
    assign mapped = is_result || (paddr == `AF_CTRL_OFS) || (paddr == `AF_OFFSET_OFS)
        || (paddr == `AF_GAIN_OFS) || (paddr == `AF_STATUS_OFS);
    // Bus phases
    assign setup = psel && !penable;
    assign access = psel && penable;

    // Zero-wait slave; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // Read mux, captured in the setup cycle
    always_comb begin
        // Unmapped addresses read as zero
        rdata = 32'h0000_0000;
        if (is_result) begin
            rdata = {16'h0000, r.result[idx[3:0]]};
        end else if (paddr == `AF_CTRL_OFS) begin
            rdata = {30'h0000_0000, r.osr};
        end else if (paddr == `AF_OFFSET_OFS) begin
            rdata = {16'h0000, r.offset};
        end else if (paddr == `AF_GAIN_OFS) begin
            rdata = {16'h0000, r.gain};
        end else if (paddr == `AF_STATUS_OFS) begin
            rdata = {24'h00_0000, r.last_step, 3'h0, r.state == af_pkg::AF_CONVERT};
        end
    end

    // ----------------------------------------------------------------
    // Filter and calibration datapath
    // ----------------------------------------------------------------

    // Sinc3 integrators on each modulator sample, combs on each decimation
    always_comb begin
        // Modulator bit as +1 or -1
        x = mod_bit ? 21'h000001 : 21'h1fffff;
        // Three cascaded integrators
        i1_n = r.i1 + x;
        i2_n = r.i2 + i1_n;
        i3_n = r.i3 + i2_n;
        // Combs see the integrator value of this sample
        c1 = i3_n - r.d1;
        c2 = c1 - r.d2;
        c3 = c2 - r.d3;
        // A sinc3 output falls due after every 64th sample
        dec_tick = r.cnt[0] && (r.cnt[7:1] % `AF_SINC3_DEC == 7'h3f);
        // Sinc1 sum of settled sinc3 outputs
        acc_n = r.acc + {{3{c3[20]}}, c3};
        // Last modulator sample of the conversion
        last = (r.cnt == conv_len(r.osr) - 11'h001);
        // Shift grows with the number of summed outputs
        shamt = `AF_SHIFT_BASE + {1'b0, r.osr};
        raw_wide = $signed({{14{acc_n[23]}}, acc_n}) >>> shamt;
        raw16 = sat16(raw_wide);
    end

    // Offset subtraction, gain scaling, rounding and clipping
    always_comb begin
        is_temp = (r.pos_sel == af_pkg::AF_POS_TEMP);
        // One offset count is two codes at gain 4, one otherwise
        if (r.gsel == af_pkg::AF_GAIN_X4 || r.gsel == af_pkg::AF_GAIN_X4_ALT) begin
            off_eff = {r.offset[15], r.offset, 1'b0};
        end else begin
            off_eff = {{2{r.offset[15]}}, r.offset};
        end
        // Offset subtracted first, in signed arithmetic
        diff = {{3{raw16[15]}}, raw16} - {off_eff[17], off_eff};
        // Unity plus the signed correction, 16 fraction bits
        factor = `AF_GAIN_UNITY + {{2{r.gain[15]}}, r.gain};
        // Signed product of difference and factor
        prod = $signed(diff) * $signed(factor);
        // Round half up, then drop the fraction bits
        rounded = ($signed({prod[36], prod}) + `AF_ROUND_HALF) >>> `AF_GAIN_FRAC;
        // Temperature steps keep the raw code
        corrected = is_temp ? raw16 : sat16(rounded);
    end

    // Current-channel code clipping
    assign cur_s = $signed(cur_value);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------

    always_comb begin
        // Hold everything; done is a one-cycle pulse
        n = r;
        n.done = 1'b0;

        // Register writes take effect in the access phase
        if (access && pwrite) begin
            if (paddr == `AF_CTRL_OFS) begin
                n.osr = pwdata[`AF_CTRL_OSR_LSB +: 2];
            end else if (paddr == `AF_OFFSET_OFS) begin
                n.offset = pwdata[15:0];
            end else if (paddr == `AF_GAIN_OFS) begin
                n.gain = pwdata[15:0];
            end
        end
        // Read data captured in setup so it stands in access
        if (setup) begin
            n.prdata = rdata;
        end

        // Conversion sequencing
        unique case (r.state)
            af_pkg::AF_IDLE: begin
                // A start is taken only while idle
                if (step_start) begin
                    n.state = af_pkg::AF_CONVERT;
                    n.step = step_index;
                    n.pos_sel = af_pkg::af_pos_type'(step_positive_select);
                    n.neg_sel = step_negative_select;
                    n.gsel = af_pkg::af_gain_type'(step_gain_select);
                    n.cnt = 11'h000;
                    n.dec = 4'h0;
                    // Filter history cleared for every conversion
                    n.i1 = 21'h000000;
                    n.i2 = 21'h000000;
                    n.i3 = 21'h000000;
                    n.d1 = 21'h000000;
                    n.d2 = 21'h000000;
                    n.d3 = 21'h000000;
                    n.acc = 24'h00_0000;
                end
            end
            af_pkg::AF_CONVERT: begin
                // One count per main clock
                n.cnt = r.cnt + 11'h001;
                // Integrators advance on modulator samples only
                if (r.cnt[0]) begin
                    n.i1 = i1_n;
                    n.i2 = i2_n;
                    n.i3 = i3_n;
                end
                // Comb delays and sinc1 sum at each sinc3 output
                if (dec_tick) begin
                    n.d1 = i3_n;
                    n.d2 = c1;
                    n.d3 = c2;
                    n.dec = r.dec + 4'h1;
                    // The first two sinc3 outputs are not settled
                    if (r.dec >= `AF_SINC3_SETTLE) begin
                        n.acc = acc_n;
                    end
                end
                // Settled result stored as the conversion ends
                if (last) begin
                    n.state = af_pkg::AF_IDLE;
                    n.result[r.step] = corrected;
                    n.last_step = r.step;
                    n.done = 1'b1;
                end
            end
        endcase

        // Current-channel clipping
        if (cur_valid) begin
            if (cur_s > `AF_POS_FS24) begin
                n.cur_code = 24'h7fffff;
            end else if (cur_s < `AF_NEG_FS24) begin
                n.cur_code = 24'h800000;
            end else begin
                n.cur_code = cur_s[23:0];
            end
        end
    end

    // Register the state; calibration values are volatile
    // The host must reload offset and gain after any reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------

    // Selectors, negative forced to ground for any non-pin positive choice
    always_comb begin
        aux_input_selector_pos = r.pos_sel;
        // Pins connect only for the eight input choices
        analog_inputs_connected = (r.pos_sel <= af_pkg::AF_POS_IN7);
        aux_input_selector_neg = analog_inputs_connected ? r.neg_sel : 1'b0;
        pga_gain = r.gsel;
    end

    // Registered read data and modulator enable
    assign prdata = r.prdata;
    assign mod_clk_en = (r.state == af_pkg::AF_CONVERT) && r.cnt[0];
    // Sequencer handshake and current code
    assign step_done = r.done;
    assign aux_busy = (r.state == af_pkg::AF_CONVERT);
    assign cur_code = r.cur_code;

endmodule

// ===== af_filter_cal_monitor.sv
// Port checker for the auxiliary filter and calibration block.
// Assumes a bind onto af_filter_cal from the testbench file.
`timescale 1ns/1ps
`include "af_defines.svh"

module af_filter_cal_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic step_start,
    input wire logic [3:0] step_positive_select,
    input wire logic [3:0] aux_input_selector_pos,
    input wire logic aux_input_selector_neg,
    input wire logic analog_inputs_connected,
    input wire logic mod_clk_en,
    input wire logic step_done,
    input wire logic aux_busy,
    input wire logic cur_valid,
    input wire logic [31:0] cur_value,
    input wire logic [23:0] cur_code
);
    // ----------------------------------------------------------------
    // Helper logic
    // ----------------------------------------------------------------
    logic [1:0] osr_r;
    logic [11:0] cnt_r;
    logic [10:0] len;
    logic [23:0] clip;
    logic mapped;

    // Shadow of the oversampling select and edges since an accepted start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osr_r <= 2'h0;
            cnt_r <= 12'h000;
        end else begin
            if (psel && penable && pwrite && paddr == 8'h00) begin
                osr_r <= pwdata[1:0];
            end
            if (step_start && !aux_busy) begin
                cnt_r <= 12'h001;
            end else if (cnt_r != 12'h000 && cnt_r != 12'hfff) begin
                cnt_r <= cnt_r + 12'h001;
            end
        end
    end

    // Expected conversion length, clipped current code and address decode
    assign len = osr_r == 2'h0 ? `AF_CONV_OSR64 : osr_r == 2'h1 ? `AF_CONV_OSR128 :
                 osr_r == 2'h2 ? `AF_CONV_OSR256 : `AF_CONV_OSR512;
    assign clip = $signed(cur_value) > `AF_POS_FS24 ? 24'h7fffff :
                  $signed(cur_value) < `AF_NEG_FS24 ? 24'h800000 : cur_value[23:0];
    assign mapped = paddr < 8'h10 || (paddr >= 8'h40 && paddr <= 8'h7c);

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    sequence s_accept;
        step_start && !aux_busy;
    endsequence
    sequence s_finish;
        step_done && !aux_busy ##1 !step_done;
    endsequence
    property p_start_busy;
        s_accept |=> aux_busy [*8];
    endproperty
    property p_sel_latch;
        s_accept |=> aux_input_selector_pos == $past(step_positive_select);
    endproperty
    property p_neg_forced;
        aux_input_selector_pos > 4'h7 |-> !aux_input_selector_neg && !analog_inputs_connected;
    endproperty
    property p_pins;
        aux_input_selector_pos <= 4'h7 |-> analog_inputs_connected;
    endproperty
    property p_mod_half;
        mod_clk_en |=> !mod_clk_en;
    endproperty
    property p_mod_busy;
        mod_clk_en |-> aux_busy;
    endproperty
    // Done is launched one edge before it is sampled here
    property p_conv_len;
        step_done |-> $past(cnt_r) == {1'b0, len};
    endproperty
    property p_done;
        step_done |-> s_finish;
    endproperty
    property p_cur;
        cur_valid |=> cur_code == $past(clip);
    endproperty
    property p_apb_err;
        psel && penable && paddr[1:0] == 2'h0 |-> pready && pslverr == !mapped;
    endproperty

    a_start_busy: assert property (p_start_busy) else $error("busy not held after start");
    a_sel_latch: assert property (p_sel_latch) else $error("selector not latched");
    a_neg_forced: assert property (p_neg_forced) else $error("negative not grounded");
    a_pins: assert property (p_pins) else $error("pins not connected");
    a_mod_half: assert property (p_mod_half) else $error("modulator rate wrong");
    a_mod_busy: assert property (p_mod_busy) else $error("modulator idle pulse");
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
    a_done: assert property (p_done) else $error("done pulse wrong");
    a_cur: assert property (p_cur) else $error("current code wrong");
    a_apb_err: assert property (p_apb_err) else $error("slave error wrong");
endmodule

// ===== af_mod_model.sv
// Modulator bitstream model for the auxiliary filter block.
// Assumes the bench picks the level of the stream per conversion.
`timescale 1ns/1ps

module af_mod_model (
    input wire logic pclk,
    input wire logic mod_clk_en,
    input wire logic level,
    output logic mod_bit
);
    logic junk_r = 1'b0;

    // Line toggles outside sample cycles so stale values never pass
    always_ff @(posedge pclk) begin
        junk_r <= ~junk_r;
    end

    // One bit per modulator period, at half the main clock
    assign mod_bit = mod_clk_en ? level : junk_r;
endmodule

// ===== testbench.sv
// Self-checking bench for af_filter_cal over APB and the step port.
// Assumes af_mod_model and af_filter_cal_monitor are compiled first.
`timescale 1ns/1ps

module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, step_start, neg, lvl;
    logic mod_bit, sel_neg, connected, mod_clk_en, step_done, aux_busy, cur_valid, rerr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata, cur_value;
    logic [3:0] idx, pos, sel_pos;
    logic [1:0] gsel, pga_gain;
    logic [23:0] cur_code;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    int lens[4] = '{384, 512, 768, 1280};

    af_filter_cal i_af_filter_cal (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .step_start(step_start), .step_index(idx),
        .step_positive_select(pos), .step_negative_select(neg), .step_gain_select(gsel),
        .mod_bit(mod_bit), .aux_input_selector_pos(sel_pos), .aux_input_selector_neg(sel_neg),
        .analog_inputs_connected(connected), .pga_gain(pga_gain), .mod_clk_en(mod_clk_en),
        .step_done(step_done), .aux_busy(aux_busy), .cur_valid(cur_valid),
        .cur_value(cur_value), .cur_code(cur_code));
    af_mod_model i_af_mod_model (.pclk(pclk), .mod_clk_en(mod_clk_en), .level(lvl),
        .mod_bit(mod_bit));

    // Clock and cycle ceiling
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // One sequencer step; counts edges from acceptance to completion
    task automatic run_step(input logic [3:0] p, input logic n, input logic [1:0] g,
                            input logic [3:0] i, input logic l, input int len);
        int c;
        c = 0;
        @(posedge pclk);
        lvl <= l;
        step_start <= 1'b1;
        pos <= p;
        neg <= n;
        gsel <= g;
        idx <= i;
        @(posedge pclk);
        step_start <= 1'b0;
        do begin
            @(posedge pclk);
            c++;
        end while (step_done !== 1'b1 && c < 2000);
        // Done is seen one edge after the edge that launches it
        check("conv_len", c - 1, len);
        apb(1'b0, 8'h40 + {2'h0, i, 2'h0}, 32'h0);
    endtask

    initial begin
        {psel, penable, pwrite, step_start, neg, lvl, cur_valid} = 7'h00;
        {paddr, pwdata, idx, pos, gsel, cur_value} = '0;
        presetn = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h04, 32'h0);
        check("offset_reset", rdata, 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        check("gain_reset", rdata, 32'h0);
        apb(1'b1, 8'h20, 32'h1234);
        check("unmapped_err", {31'h0, rerr}, 32'h1);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'h00, i);
            run_step(4'(i), 1'b0, 2'h0, 4'(i), 1'b1, lens[i]);
            check("full_scale", rdata, 32'h7fff);
            apb(1'b0, 8'h0c, 32'h0);
            check("status", rdata & 32'hf1, 32'(i << 4));
        end
        $display("test osr done");
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h04, 32'hfff0);
        run_step(4'h1, 1'b1, 2'h1, 4'h5, 1'b0, 384);
        check("neg_offset", rdata, 32'h8010);
        check("sel_pos", sel_pos, 4'h1);
        check("sel_neg", sel_neg, 1'b1);
        apb(1'b1, 8'h04, 32'h0010);
        apb(1'b1, 8'h08, 32'h8000);
        run_step(4'h2, 1'b0, 2'h0, 4'h6, 1'b1, 384);
        check("half_gain", rdata, 32'h3ff8);
        run_step(4'h8, 1'b1, 2'h0, 4'h7, 1'b1, 384);
        check("temp_bypass", rdata, 32'h7fff);
        check("temp_neg", {sel_neg, connected}, 2'h0);
        apb(1'b1, 8'h08, 32'h0);
        run_step(4'h0, 1'b0, 2'h2, 4'h8, 1'b1, 384);
        check("gain4_offset", rdata, 32'h7fdf);
        check("pga_gain", pga_gain, 2'h2);
        run_step(4'h9, 1'b1, 2'h3, 4'h9, 1'b1, 384);
        check("gain4_alt", rdata, 32'h7fdf);
        check("short_neg", {sel_neg, connected}, 2'h0);
        $display("test calibration done");
        for (int i = 0; i < 3; i++) begin
            @(posedge pclk);
            cur_valid <= 1'b1;
            cur_value <= i == 0 ? 32'h00900000 : i == 1 ? 32'hff000000 : 32'h00001234;
            @(posedge pclk);
            cur_valid <= 1'b0;
            @(posedge pclk);
            check("cur_code", cur_code, i == 0 ? 24'h7fffff : i == 1 ? 24'h800000 : 24'h1234);
        end
        $display("test current done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h04, 32'h0);
        check("offset_volatile", rdata, 32'h0);
        apb(1'b1, 8'h04, 32'h0010);
        apb(1'b0, 8'h04, 32'h0);
        check("offset_rewrite", rdata, 32'h10);
        $display("test reset done");
        finish_test();
    end
endmodule

bind af_filter_cal af_filter_cal_monitor i_af_filter_cal_monitor (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .step_start(step_start),
    .step_positive_select(step_positive_select),
    .aux_input_selector_pos(aux_input_selector_pos),
    .aux_input_selector_neg(aux_input_selector_neg),
    .analog_inputs_connected(analog_inputs_connected), .mod_clk_en(mod_clk_en),
    .step_done(step_done), .aux_busy(aux_busy), .cur_valid(cur_valid),
    .cur_value(cur_value), .cur_code(cur_code));
